// File: logic/spm_pkg.sv
// Purpose: Shared constants and types for the switch port config bank
// Assumes: AXI4-Lite word access, 50 MHz aclk
// Notes: Offsets are byte addresses within the bank
package spm_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_DOWNSTREAM_POWER_EVENT_CONTROL = 8'h9C;
	localparam logic [7:0] OFS_EEPROM_CONTROL = 8'hA0;
	localparam logic [7:0] OFS_EEPROM_ADDRESS_DATA = 8'hA4;
	localparam logic [7:0] OFS_DEBUG_OUTPUT_CONTROL = 8'hA8;
	localparam logic [7:0] OFS_DEBUG_OUTPUT_DATA = 8'hAC;
	localparam logic [7:0] OFS_SUBSYSTEM_ID_CAPABILITY_HEADER = 8'hB0;
	localparam logic [7:0] OFS_SUBSYSTEM_IDENTIFIERS = 8'hB4;
	localparam logic [7:0] OFS_INT_STATUS = 8'hE0;
	localparam logic [7:0] OFS_INT_MASK = 8'hE4;
	// Power event control fields
	localparam int PME_CAP_BIT = 0;
	localparam int TURNOFF_BIT = 1;
	localparam int PORT_POWER_BIT = 2;
	localparam int PORT_RESET_BIT = 3;
	localparam int LINK_STATUS_LSB = 16;
	localparam logic PME_CAP_RST = 1'b1;
	localparam logic PORT_POWER_RST = 1'b1;
	localparam logic PORT_RESET_RST = 1'b1;
	// EEPROM control fields
	localparam int EE_START_BIT = 0;
	localparam int EE_CMD_LSB = 1;
	localparam int EE_AUTOLOAD_STATUS_BIT = 4;
	localparam int EE_AUTOLOAD_DISABLE_BIT = 5;
	localparam int EE_RATE_LSB = 6;
	localparam int EE_STATUS_LSB = 8;
	localparam logic EE_AUTOLOAD_DISABLE_RST = 1'b1;
	localparam logic [1:0] EE_RATE_RST = 2'h1;
	localparam logic [1:0] EE_RATE_DIV64 = 2'h1;
	localparam logic [1:0] EE_RATE_TEST = 2'h3;
	localparam int EE_DIV_NORMAL = 64;
	localparam int EE_DIV_TEST = 4;
	// Serial frame lengths in bits
	localparam logic [5:0] FRAME_LONG = 6'h28;
	localparam logic [5:0] FRAME_STATUS = 6'h10;
	localparam logic [5:0] FRAME_SHORT = 6'h08;
	// EEPROM commands
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_WRSTATUS = 3'h1,
		CMD_WRITE = 3'h2,
		CMD_READ = 3'h3,
		CMD_WRDISABLE = 3'h4,
		CMD_RDSTATUS = 3'h5,
		CMD_WRENABLE = 3'h6,
		CMD_SPARE = 3'h7
	} spm_ee_cmd_t;
	// Debug output fields
	localparam int DBG_PORT_LSB = 5;
	localparam int DBG_START_BIT = 8;
	localparam int DBG_LED_LSB = 24;
	localparam logic [4:0] DBG_MODE_LTSSM = 5'h0C;
	localparam int LTSSM_STATES = 10;
	// Capability header
	localparam logic [7:0] CAP_ID = 8'h0D;
	localparam logic [7:0] CAP_NEXT_PTR = 8'hC0;
	// Interrupt status bits
	localparam int INT_EE_DONE = 0;
	localparam int INT_TURNOFF = 1;
	localparam int INT_BITS = 2;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SHIFT = 3'h2,
		ST_DONE = 3'h4
	} spm_state_t;
	// EEPROM pin group
	typedef struct packed {
		logic sck;
		logic cs_n;
		logic mosi;
	} spm_ee_pins_t;
endpackage

// File: logic/spm_config_regs.sv
// Purpose: Downstream power, EEPROM access, debug select and subsystem ID
// Assumes: One clock, synchronous active-low reset, AXI4-Lite slave
// Notes: Serial EEPROM uses SPI mode 0, MSB first
// Notes on behaviour
// - Power event capability readable, resets one, loadable
// - Writing turnoff request while the bit is zero sends turnoff message
// - Port power drives its GPIO pin while the capability bit is one
// - Port reset bit drives active-low device reset
// - Two-bit link power state readable
// - Start bit launches one EEPROM cycle
// - Three-bit command selects EEPROM operation
// - Autoload status one only after good load
// - Autoload disable makes a later load set autoload status zero, resets one
// - Clock rate field sets EEPROM serial clock
// - Status bits 8,9 mirror busy and latch
// - Bits 10,11,15 writable; 12-14 read zero
// - Address low half, data high half
// - Debug mode, port select and start
// - Mode 0Ch shows LTSSM state one-hot
// - Capability header reads 0Dh and C0h
// - Subsystem vendor and device identifiers readable
//
// Added by the designer: the AXI4-Lite register port.
module spm_config_regs #(
	parameter int PORT_NUM = 1,
	parameter int DEBUG_PORTS = 8,
	parameter int DIV_NORMAL = spm_pkg::EE_DIV_NORMAL,
	parameter int DIV_TEST = spm_pkg::EE_DIV_TEST
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	output logic irq,
	// Sideband default load
	input wire logic sb_load,
	input wire logic sb_load_ok,
	input wire logic sb_pme_cap,
	input wire logic [15:0] sb_subsystem_vendor_identifier,
	input wire logic [15:0] sb_subsystem_device_identifier,
	// Downstream port
	output logic turnoff_req,
	output logic dev_rst_n,
	output logic [4:0] gpio_out,
	output logic [4:0] gpio_oe_n,
	input wire logic [1:0] link_pm_state,
	// Debug sources and LED
	input wire logic [DEBUG_PORTS*spm_pkg::LTSSM_STATES-1:0] ltssm_onehot,
	output logic [7:0] led_debug,
	// EEPROM pins
	output spm_pkg::spm_ee_pins_t ee_pins,
	input wire logic ee_miso
);
	import spm_pkg::*;

	// Register state
	logic pme_cap_ff; // Capability, loadable default
	logic turnoff_ff; // Turnoff request bit
	logic port_power_ff; // Port power bit
	logic port_reset_ff; // Port reset bit, high releases
	logic [1:0] link_ff; // Sampled link power state
	logic ee_start_ff; // Cycle in progress request
	logic [2:0] ee_cmd_ff; // Programmed command
	logic autoload_ok_ff; // Autoload result
	logic autoload_dis_ff; // Autoload disable
	logic [1:0] ee_rate_ff; // Serial clock rate code
	logic [7:0] ee_status_ff; // Status mirror
	logic [15:0] ee_addr_ff; // EEPROM address
	logic [15:0] ee_data_ff; // EEPROM data
	logic [4:0] dbg_mode_ff; // Debug mode select
	logic [2:0] dbg_port_ff; // Debug port select
	logic dbg_start_ff; // Debug output start
	logic [7:0] led_ff; // LED debug, write only
	logic [31:0] dbg_data_ff; // Debug output data
	logic [15:0] subsystem_vendor_identifier_ff; // Subsystem vendor id
	logic [15:0] subsystem_device_identifier_ff; // Subsystem device id
	logic [INT_BITS-1:0] int_stat_ff; // Sticky events
	logic [INT_BITS-1:0] int_mask_ff; // Enables, one passes
	// Bus state
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [1:0] rresp_ff;
	logic [31:0] rdata_ff;
	// Serial engine state
	spm_state_t state_ff;
	spm_state_t nxt_state;
	logic [7:0] div_ff; // Half period counter
	logic sck_ff;
	logic [5:0] bits_ff; // Bits left in frame
	logic [39:0] tx_ff; // Outgoing shift register
	logic [39:0] rx_ff; // Incoming shift register
	logic [2:0] run_cmd_ff; // Command of current frame

	// Merge write data by byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Mapped offset check
	function automatic logic mapped(input logic [7:0] a);
		return a == OFS_DOWNSTREAM_POWER_EVENT_CONTROL ||
			a == OFS_EEPROM_CONTROL || a == OFS_EEPROM_ADDRESS_DATA ||
			a == OFS_DEBUG_OUTPUT_CONTROL || a == OFS_DEBUG_OUTPUT_DATA ||
			a == OFS_SUBSYSTEM_ID_CAPABILITY_HEADER ||
			a == OFS_SUBSYSTEM_IDENTIFIERS || a == OFS_INT_STATUS ||
			a == OFS_INT_MASK;
	endfunction

	// Register words as software sees them
	wire [31:0] w_pwr = {14'h0000, link_ff, 12'h000, port_reset_ff,
		port_power_ff, turnoff_ff, pme_cap_ff};
	wire [31:0] w_eec = {16'h0000, ee_status_ff[7], 3'h0,
		ee_status_ff[3:0], ee_rate_ff, autoload_dis_ff, autoload_ok_ff,
		ee_cmd_ff, ee_start_ff};
	wire [31:0] w_eead = {ee_data_ff, ee_addr_ff};
	wire [31:0] w_dbgc = {23'h000000, dbg_start_ff, dbg_port_ff,
		dbg_mode_ff};
	wire [31:0] w_cap = {16'h0000, CAP_NEXT_PTR, CAP_ID};
	wire [31:0] w_ids = {subsystem_device_identifier_ff, subsystem_vendor_identifier_ff};
	wire [31:0] w_ist = {{(32-INT_BITS){1'b0}}, int_stat_ff};
	wire [31:0] w_imk = {{(32-INT_BITS){1'b0}}, int_mask_ff};

	// Word selected by an address
	function automatic logic [31:0] word_at(input logic [7:0] a);
		unique case (a)
			OFS_DOWNSTREAM_POWER_EVENT_CONTROL: return w_pwr;
			OFS_EEPROM_CONTROL: return w_eec;
			OFS_EEPROM_ADDRESS_DATA: return w_eead;
			OFS_DEBUG_OUTPUT_CONTROL: return w_dbgc;
			OFS_DEBUG_OUTPUT_DATA: return dbg_data_ff;
			OFS_SUBSYSTEM_ID_CAPABILITY_HEADER: return w_cap;
			OFS_SUBSYSTEM_IDENTIFIERS: return w_ids;
			OFS_INT_STATUS: return w_ist;
			OFS_INT_MASK: return w_imk;
			default: return 32'h00000000;
		endcase
	endfunction

	// Write channel: take address and data together, one response open
	wire wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	wire [31:0] wr_word = merge(word_at(s_axi_awaddr), s_axi_wdata,
		s_axi_wstrb);
	wire wr_pwr = wr_fire && s_axi_awaddr == OFS_DOWNSTREAM_POWER_EVENT_CONTROL;
	wire wr_eec = wr_fire && s_axi_awaddr == OFS_EEPROM_CONTROL;
	wire wr_eead = wr_fire && s_axi_awaddr == OFS_EEPROM_ADDRESS_DATA;
	wire wr_dbgc = wr_fire && s_axi_awaddr == OFS_DEBUG_OUTPUT_CONTROL;
	wire wr_ist = wr_fire && s_axi_awaddr == OFS_INT_STATUS;
	wire wr_imk = wr_fire && s_axi_awaddr == OFS_INT_MASK;
	// Read channel: one read open at a time
	wire rd_fire = s_axi_arvalid && !rvalid_ff;
	// Serial engine control
	wire busy = state_ff != ST_IDLE;
	wire launch = wr_eec && wr_word[EE_START_BIT] && !busy;
	wire [2:0] launch_cmd = wr_word[EE_CMD_LSB +: 3];
	wire [7:0] half_div = (ee_rate_ff == EE_RATE_TEST) ?
		8'(DIV_TEST / 2) : 8'(DIV_NORMAL / 2);
	wire tick = state_ff == ST_SHIFT && div_ff == half_div - 8'h01;
	wire last_bit = tick && sck_ff && bits_ff == 6'h01;
	wire ee_done = state_ff == ST_DONE;
	wire turnoff_set = wr_pwr && wr_word[TURNOFF_BIT] && !turnoff_ff;
	wire [INT_BITS-1:0] int_events;
	wire [LTSSM_STATES-1:0] ltssm_sel;
	wire [7:0] status_out = {ee_status_ff[7], 3'h0, ee_status_ff[3:2],
		2'h0};

	assign int_events[INT_EE_DONE] = ee_done;
	assign int_events[INT_TURNOFF] = turnoff_set;
	assign ltssm_sel = (32'(dbg_port_ff) < DEBUG_PORTS) ?
		ltssm_onehot[dbg_port_ff*LTSSM_STATES +: LTSSM_STATES] :
		{LTSSM_STATES{1'b0}};

	// Bus outputs
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = rd_fire;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign irq = |(int_stat_ff & int_mask_ff);
	// Port pins; only this port's GPIO is driven, oe low drives
	assign dev_rst_n = port_reset_ff;
	assign led_debug = led_ff;
	always_comb begin
		gpio_out = 5'h00;
		gpio_oe_n = 5'h1F;
		gpio_out[PORT_NUM-1] = port_power_ff;
		gpio_oe_n[PORT_NUM-1] = !pme_cap_ff;
	end
	assign ee_pins.sck = sck_ff;
	assign ee_pins.cs_n = state_ff != ST_SHIFT;
	assign ee_pins.mosi = tx_ff[39];

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff <= mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Read response, data captured when the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h00000000;
		end else if (rd_fire) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_ff <= word_at(s_axi_araddr);
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// Power event control and sideband defaults
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pme_cap_ff <= PME_CAP_RST;
			turnoff_ff <= 1'b0;
			port_power_ff <= PORT_POWER_RST;
			port_reset_ff <= PORT_RESET_RST;
			link_ff <= 2'h0;
			subsystem_vendor_identifier_ff <= 16'h0000;
			subsystem_device_identifier_ff <= 16'h0000;
			turnoff_req <= 1'b0;
		end else begin
			link_ff <= link_pm_state;
			turnoff_req <= turnoff_set;
			if (wr_pwr) begin
				turnoff_ff <= wr_word[TURNOFF_BIT];
				port_power_ff <= wr_word[PORT_POWER_BIT];
				port_reset_ff <= wr_word[PORT_RESET_BIT];
			end
			if (sb_load) begin
				pme_cap_ff <= sb_pme_cap;
				subsystem_vendor_identifier_ff <= sb_subsystem_vendor_identifier;
				subsystem_device_identifier_ff <= sb_subsystem_device_identifier;
			end
		end
	end

	// EEPROM control fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ee_start_ff <= 1'b0;
			ee_cmd_ff <= CMD_NONE;
			autoload_ok_ff <= 1'b0;
			autoload_dis_ff <= EE_AUTOLOAD_DISABLE_RST;
			ee_rate_ff <= EE_RATE_RST;
			ee_status_ff <= 8'h00;
			ee_addr_ff <= 16'h0000;
			ee_data_ff <= 16'h0000;
		end else begin
			if (sb_load) begin
				autoload_ok_ff <= sb_load_ok && !autoload_dis_ff;
			end
			if (wr_eec && !busy) begin
				ee_cmd_ff <= launch_cmd;
				autoload_dis_ff <= wr_word[EE_AUTOLOAD_DISABLE_BIT];
				ee_rate_ff <= wr_word[EE_RATE_LSB +: 2];
				ee_status_ff[3:2] <= wr_word[EE_STATUS_LSB+2 +: 2];
				ee_status_ff[7] <= wr_word[EE_STATUS_LSB+7];
			end
			if (launch) begin
				ee_start_ff <= 1'b1;
			end else if (ee_done) begin
				ee_start_ff <= 1'b0;
			end
			if (wr_eead && !busy) begin
				ee_addr_ff <= wr_word[15:0];
				ee_data_ff <= wr_word[31:16];
			end
			if (ee_done && run_cmd_ff == CMD_READ) begin
				ee_data_ff <= rx_ff[15:0];
			end
			if (ee_done && run_cmd_ff == CMD_RDSTATUS) begin
				ee_status_ff <= {rx_ff[7], 3'h0, rx_ff[3:0]};
			end
		end
	end

	// Serial engine next state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (launch) begin
					nxt_state = (launch_cmd == CMD_NONE ||
						launch_cmd == CMD_SPARE) ? ST_DONE : ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (last_bit) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Serial engine state and clock divider
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			div_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			div_ff <= (tick || state_ff != ST_SHIFT) ? 8'h00 : div_ff + 8'h01;
		end
	end

	// Frame load, SPI mode 0 shifting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_ff <= 1'b0;
			bits_ff <= 6'h00;
			tx_ff <= 40'h0000000000;
			rx_ff <= 40'h0000000000;
			run_cmd_ff <= CMD_NONE;
		end else if (launch) begin
			sck_ff <= 1'b0;
			run_cmd_ff <= launch_cmd;
			unique case (launch_cmd)
				CMD_WRITE, CMD_READ: begin
					bits_ff <= FRAME_LONG;
					tx_ff <= {5'h00, launch_cmd, ee_addr_ff, ee_data_ff};
				end
				CMD_WRSTATUS, CMD_RDSTATUS: begin
					bits_ff <= FRAME_STATUS;
					tx_ff <= {5'h00, launch_cmd, status_out, 24'h000000};
				end
				default: begin
					bits_ff <= FRAME_SHORT;
					tx_ff <= {5'h00, launch_cmd, 32'h00000000};
				end
			endcase
		end else if (tick) begin
			sck_ff <= !sck_ff;
			if (!sck_ff) begin
				rx_ff <= {rx_ff[38:0], ee_miso};
			end else begin
				tx_ff <= {tx_ff[38:0], 1'b0};
				bits_ff <= bits_ff - 6'h01;
			end
		end
	end

	// Debug output selection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dbg_mode_ff <= 5'h00;
			dbg_port_ff <= 3'h0;
			dbg_start_ff <= 1'b0;
			led_ff <= 8'h00;
			dbg_data_ff <= 32'h00000000;
		end else begin
			if (wr_dbgc) begin
				dbg_mode_ff <= wr_word[4:0];
				dbg_port_ff <= wr_word[DBG_PORT_LSB +: 3];
				dbg_start_ff <= wr_word[DBG_START_BIT];
				// Byte 3 of the merged word, zero where its strobe is low
				led_ff <= wr_word[DBG_LED_LSB +: 8];
			end
			if (dbg_start_ff && dbg_mode_ff == DBG_MODE_LTSSM) begin
				dbg_data_ff <= {{(32-LTSSM_STATES){1'b0}}, ltssm_sel};
			end else begin
				dbg_data_ff <= 32'h00000000;
			end
		end
	end

	// Interrupt status, set wins over write-one-to-clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_ff <= {INT_BITS{1'b0}};
			int_mask_ff <= {INT_BITS{1'b0}};
		end else begin
			int_stat_ff <= (int_stat_ff &
				~(wr_ist ? wr_word[INT_BITS-1:0] : {INT_BITS{1'b0}})) |
				int_events;
			if (wr_imk) begin
				int_mask_ff <= wr_word[INT_BITS-1:0];
			end
		end
	end
endmodule // spm_config_regs

// File: verification/spm_props.sv
// Purpose: Port checks for the switch port config bank
// Assumes: One clock, synchronous active-low reset, PORT_NUM of 1
// Notes: Bound onto every instance of the bank
module spm_props (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus side
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	// Device side
	input wire logic turnoff_req,
	input wire logic dev_rst_n,
	input wire logic [4:0] gpio_out,
	input wire logic [4:0] gpio_oe_n,
	input wire spm_pkg::spm_ee_pins_t ee_pins
);
	import spm_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Write of the low byte of the power event word
	sequence s_wr_pwr;
		s_axi_awvalid && s_axi_awready && s_axi_wstrb[0] &&
		s_axi_awaddr == OFS_DOWNSTREAM_POWER_EVENT_CONTROL;
	endsequence
	// Start write carrying a framed command, select high two cycles
	sequence s_wr_start;
		ee_pins.cs_n && $past(ee_pins.cs_n) &&
		s_axi_awvalid && s_axi_awready && s_axi_wstrb[0] &&
		s_axi_awaddr == OFS_EEPROM_CONTROL && s_axi_wdata[0] &&
		s_axi_wdata[3:1] != 3'h0 && s_axi_wdata[3:1] != 3'h7;
	endsequence
	// Read accepted at a given offset
	sequence s_rd(logic [7:0] a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
	endsequence
	a_rst_follows: assert property (s_wr_pwr |=> dev_rst_n == $past(s_axi_wdata[3]))
		else $error("device reset does not follow written bit");
	a_power_pin: assert property (s_wr_pwr |=> gpio_out[0] == $past(s_axi_wdata[2]))
		else $error("power pin does not follow written bit");
	a_spare_pins: assert property (gpio_out[4:1] == 4'h0 && gpio_oe_n[4:1] == 4'hF)
		else $error("pin of another port driven");
	a_turnoff_once: assert property (turnoff_req |=> !turnoff_req)
		else $error("turnoff request longer than one cycle");
	a_turnoff_cause: assert property (turnoff_req |-> $past(s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h9C && s_axi_wdata[1]))
		else $error("turnoff request without a write");
	a_frame_launch: assert property (s_wr_start |=> !ee_pins.cs_n)
		else $error("start did not open a frame");
	a_idle_sck_low: assert property (ee_pins.cs_n |-> !ee_pins.sck)
		else $error("serial clock active outside frame");
	a_mosi_steady: assert property ($rose(ee_pins.sck) |-> $stable(ee_pins.mosi))
		else $error("serial out moved on rising clock");
	a_cap_header: assert property (s_rd(OFS_SUBSYSTEM_ID_CAPABILITY_HEADER) |=> s_axi_rvalid && s_axi_rdata == 32'h0000C00D)
		else $error("capability header wrong");
	a_rsvd_zero: assert property (s_rd(OFS_DOWNSTREAM_POWER_EVENT_CONTROL) |=> s_axi_rdata[15:4] == 12'h000 && s_axi_rdata[31:18] == 14'h0000)
		else $error("reserved power bits not zero");
	a_status_gap: assert property (s_rd(OFS_EEPROM_CONTROL) |=> s_axi_rdata[14:12] == 3'h0)
		else $error("status bits 12 to 14 not zero");
endmodule // spm_props

bind spm_config_regs spm_props u_props (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .turnoff_req,
	.dev_rst_n, .gpio_out, .gpio_oe_n, .ee_pins);

// File: verification/spm_ee_model.sv
// Purpose: Behavioural serial EEPROM on the far side of the engine
// Assumes: Mode 0, MSB first, opcode in the first byte
// Notes: Released data line toggles so a stale level never passes
module spm_ee_model #(
	parameter logic [15:0] RDATA = 16'hC3A5,
	parameter logic [7:0] STAT = 8'hF3
) (
	// Serial pins
	input wire spm_pkg::spm_ee_pins_t ee_pins,
	output logic ee_miso
);
	import spm_pkg::*;
	logic [39:0] fr = 40'h0; // Bits received, last one lowest
	logic [7:0] op = 8'h0; // Opcode of the frame
	int cnt = 0; // Bits in this frame
	int nbits = 0; // Bits in the last frame
	initial ee_miso = 1'b0;
	// Sample on rising clock, close frame on select release
	always @(posedge ee_pins.sck or posedge ee_pins.cs_n) begin
		if (ee_pins.cs_n) begin
			nbits <= cnt;
			cnt <= 0;
		end else begin
			fr <= {fr[38:0], ee_pins.mosi};
			cnt <= cnt + 1;
			if (cnt == 7)
				op <= {fr[6:0], ee_pins.mosi};
		end
	end
	// Drive answer bits on falling clock, else a changing pattern
	always @(negedge ee_pins.sck or posedge ee_pins.cs_n) begin
		if (!ee_pins.cs_n && op == 8'h03 && cnt >= 24 && cnt < 40)
			ee_miso <= RDATA[39 - cnt];
		else if (!ee_pins.cs_n && op == 8'h05 && cnt >= 8 && cnt < 16)
			ee_miso <= STAT[15 - cnt];
		else
			ee_miso <= ~ee_miso;
	end
endmodule // spm_ee_model

// File: verification/tb.sv
// Purpose: Self-checking bench for the switch port config bank
// Assumes: Short serial divider, EEPROM model on the pins
// Notes: Table of reads first, then hand-written cases
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import spm_pkg::*;
	// Design pins
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq, sb_load;
	logic sb_load_ok, sb_pme_cap, turnoff_req, dev_rst_n, ee_miso;
	logic [7:0] s_axi_awaddr, s_axi_araddr, led_debug;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, link_pm_state, resp;
	logic [15:0] sb_subsystem_vendor_identifier, sb_subsystem_device_identifier;
	logic [4:0] gpio_out, gpio_oe_n;
	logic [79:0] ltssm_onehot;
	logic [2:0] c;
	spm_ee_pins_t ee_pins;
	int mismatches = 0, num_checks = 0, n, en;
	localparam logic [15:0] RD = 16'hC3A5;
	// Write address, read address, expected word
	typedef struct packed {
		logic [7:0] wa;
		logic [31:0] wd;
		logic [7:0] ra;
		logic [31:0] ex;
	} spm_row_t;
	localparam spm_row_t rows[14] = '{
		'{8'h00, 32'h0, 8'h9C, 32'h0000000D}, '{8'h00, 32'h0, 8'hA0, 32'h60},
		'{8'h00, 32'h0, 8'hA4, 32'h0}, '{8'h00, 32'h0, 8'hA8, 32'h0},
		'{8'h00, 32'h0, 8'hAC, 32'h0}, '{8'h00, 32'h0, 8'hB0, 32'hC00D},
		'{8'h00, 32'h0, 8'hB4, 32'h0}, '{8'hA4, 32'hFFFF1234, 8'hA4, 32'hFFFF1234},
		'{8'hB0, 32'hFFFFFFFF, 8'hB0, 32'hC00D},
		'{8'hA8, 32'h1F00012C, 8'hA8, 32'h12C},
		'{8'hA8, 32'h12C, 8'hAC, 32'h2}, '{8'hA8, 32'h12B, 8'hAC, 32'h0},
		'{8'hA8, 32'h1EC, 8'hAC, 32'h80},
		'{8'hA0, 32'hFFC0, 8'hA0, 32'h8CC0}};
	localparam logic [2:0] cmds[6] = '{3'h6, 3'h2, 3'h3, 3'h5, 3'h1, 3'h4};
	spm_config_regs #(.DIV_NORMAL(4), .DIV_TEST(2)) u_spm_config_regs (.*);
	spm_ee_model #(.RDATA(RD)) u_spm_ee_model (.ee_pins(ee_pins), .ee_miso(ee_miso));
	// Clock
	always #10 aclk = ~aclk;
	// Bus write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		while (!s_axi_awready) @(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (!s_axi_bvalid) @(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	// Bus read
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Sideband load pulse
	task automatic pulse_load();
		sb_load <= 1'b1;
		@(posedge aclk);
		sb_load <= 1'b0;
		@(posedge aclk);
	endtask
	// Reset held five cycles
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	// Verdict
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard
	initial begin
		repeat (40000) @(posedge aclk);
		mismatches++;
		finish_test();
	end
	// Main sequence
	initial begin
		{aclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
		{s_axi_rready, sb_load, sb_load_ok, sb_pme_cap, link_pm_state} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, sb_subsystem_vendor_identifier, sb_subsystem_device_identifier} = 0;
		s_axi_wstrb = 4'hF;
		for (int p = 0; p < 8; p++)
			ltssm_onehot[p*10 +: 10] = 10'h001 << p;
		do_reset();
		foreach (rows[i]) begin
			if (rows[i].wa != 8'h00)
				wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra);
			`CHK("table", rows[i].ex, rdat)
		end
		wr(OFS_DEBUG_OUTPUT_CONTROL, 32'h5A000000);
		`CHK("led", 8'h5A, led_debug)
		$display("test table done");
		wr(OFS_INT_MASK, 32'h3);
		wr(OFS_DOWNSTREAM_POWER_EVENT_CONTROL, 32'h2);
		`CHK("dev reset", 1'b0, dev_rst_n)
		`CHK("port power", 1'b0, gpio_out[0])
		`CHK("turnoff irq", 1'b1, irq)
		wr(OFS_INT_STATUS, 32'h2);
		`CHK("irq clear", 1'b0, irq)
		for (int i = 0; i < 4; i++) begin
			link_pm_state <= i[1:0];
			repeat (2) @(posedge aclk);
			rd(OFS_DOWNSTREAM_POWER_EVENT_CONTROL);
			`CHK("link", {14'h0, i[1:0], 16'h0003}, rdat)
		end
		wr(OFS_DOWNSTREAM_POWER_EVENT_CONTROL, 32'hC);
		`CHK("dev run", 1'b1, dev_rst_n)
		`CHK("power on", 1'b1, gpio_out[0])
		$display("test power done");
		foreach (cmds[i]) begin
			c = cmds[i];
			wr(OFS_EEPROM_ADDRESS_DATA, 32'h5A5A0123);
			wr(OFS_EEPROM_CONTROL, {24'h0, (c == 3'h4) ? 2'h3 : 2'h1,
				2'h2, c, 1'b1});
			wr(OFS_EEPROM_ADDRESS_DATA, 32'h0);
			n = 0;
			do begin
				rd(OFS_EEPROM_CONTROL);
				n++;
			end while (rdat[0] !== 1'b0 && n < 100);
			`CHK("start clears", 1'b0, rdat[0])
			if (c == 3'h5)
				`CHK("status", 8'h83, rdat[15:8])
			en = (c == 3'h2 || c == 3'h3) ? 40 : (c == 3'h1 || c == 3'h5) ? 16 : 8;
			`CHK("opcode", {5'h0, c}, u_spm_ee_model.op)
			`CHK("frame bits", en, u_spm_ee_model.nbits)
			`CHK("done irq", 1'b1, irq)
			wr(OFS_INT_STATUS, 32'h1);
			if (c == 3'h2)
				`CHK("sent data", 16'h5A5A, u_spm_ee_model.fr[15:0])
			rd(OFS_EEPROM_ADDRESS_DATA);
			`CHK("addr data", (c == 3'h3) ? {RD, 16'h0123} : 32'h5A5A0123, rdat)
		end
		$display("test eeprom done");
		{sb_subsystem_vendor_identifier, sb_subsystem_device_identifier, sb_load_ok} <= {16'h1234, 16'hABCD, 1'b1};
		pulse_load();
		rd(OFS_EEPROM_CONTROL);
		`CHK("load blocked", 1'b0, rdat[4])
		rd(OFS_SUBSYSTEM_IDENTIFIERS);
		`CHK("ids", 32'hABCD1234, rdat)
		rd(OFS_DOWNSTREAM_POWER_EVENT_CONTROL);
		`CHK("cap off", 1'b0, rdat[0])
		`CHK("pin released", 1'b1, gpio_oe_n[0])
		wr(OFS_EEPROM_CONTROL, 32'h40);
		sb_pme_cap <= 1'b1;
		pulse_load();
		rd(OFS_EEPROM_CONTROL);
		`CHK("load ok", 2'h1, rdat[5:4])
		`CHK("pin driven", 1'b0, gpio_oe_n[0])
		$display("test sideband done");
		wr(8'h10, 32'h1);
		`CHK("bad wr", RESP_SLVERR, resp)
		rd(8'h10);
		`CHK("bad rd", RESP_SLVERR, resp)
		wr(OFS_EEPROM_ADDRESS_DATA, 32'h00FF00FF);
		s_axi_wstrb <= 4'h3;
		wr(OFS_EEPROM_ADDRESS_DATA, 32'hAAAA5555);
		s_axi_wstrb <= 4'hF;
		rd(OFS_EEPROM_ADDRESS_DATA);
		`CHK("strobes", 32'h00FF5555, rdat)
		do_reset();
		rd(OFS_EEPROM_ADDRESS_DATA);
		`CHK("reset data", 32'h0, rdat)
		rd(OFS_EEPROM_CONTROL);
		`CHK("reset ctrl", 32'h60, rdat)
		$display("test reset done");
		finish_test();
	end
endmodule // tb
